/* File: blb_cfg.svh */
//
// Purpose: Offsets, reset values and timing counts of the backlight brightness path.
// Assumes: A 200 MHz system clock.
// Notes:   Definitions only; included by the package and the design modules.
//
`ifndef BLB_CFG_SVH
`define BLB_CFG_SVH

// -------------------------------------------------------------------------------
// Register map and reset values
// -------------------------------------------------------------------------------
`define BLB_CODE_W 11
`define BLB_ADDR_BRT_LOW 8'h18
`define BLB_ADDR_BRT_HIGH 8'h19
`define BLB_BRT_LOW_RST 3'h0
`define BLB_BRT_HIGH_RST 8'h00

// -------------------------------------------------------------------------------
// Clock, sample rates and timing
// -------------------------------------------------------------------------------
`define BLB_CLK_KHZ 200000
`define BLB_RATE_SLOW_KHZ 800
`define BLB_RATE_MID_KHZ 4000
`define BLB_RATE_FAST_KHZ 24000
`define BLB_TMO_SLOW_US 25000
`define BLB_TMO_MID_US 3000
`define BLB_TMO_FAST_US 600
`define BLB_STEP_BASE_NS 1000
`define BLB_US_CYC (`BLB_CLK_KHZ / 1000)
`define BLB_STEP_CYC (`BLB_STEP_BASE_NS * (`BLB_CLK_KHZ / 1000) / 1000)

`endif

/* File: blb_pkg.sv */
//
// Purpose: Types and the duty scaling function of the backlight brightness path.
// Assumes: blb_cfg.svh supplies the code width.
// Notes:   Holds types only, plus one pure function shared by two places.
//
`include "blb_cfg.svh"

package blb_pkg;

    // -------------------------------------------------------------------------------
    // Basic types
    // -------------------------------------------------------------------------------
    // Brightness code as driven to the current sinks.
    typedef logic [`BLB_CODE_W-1:0] blb_code_t;

    // Source and ordering of brightness control.
    typedef enum logic [1:0] {
        BLB_MODE_REG = 2'h0,
        BLB_MODE_PWM = 2'h1,
        BLB_MODE_MUL_RAMP = 2'h2,
        BLB_MODE_RAMP_MUL = 2'h3
    } blb_mode_e;

    // Duty meter sequencer, one-hot.
    typedef enum logic [1:0] {
        BLB_DM_MEASURE = 2'b01,
        BLB_DM_DIVIDE = 2'b10
    } blb_dm_state_e;

    // -------------------------------------------------------------------------------
    // State records
    // -------------------------------------------------------------------------------
    // Duty meter state.
    typedef struct packed {
        blb_dm_state_e st;
        logic lvl_prev;
        logic seen_edge;
        logic [7:0] div_cnt;
        logic [19:0] hi_cnt;
        logic [19:0] per_cnt;
        logic [19:0] per_lat;
        logic [20:0] rem;
        logic [10:0] quo;
        logic [3:0] idx;
        logic [22:0] tmo_cnt;
        logic timeout;
        blb_code_t duty;
    } blb_dm_s;

    // Ramper state.
    typedef struct packed {
        blb_code_t code;
        blb_code_t prev_tgt;
        logic [7:0] ns_cnt;
        logic [14:0] us_cnt;
    } blb_rmp_s;

    // Top level state.
    typedef struct packed {
        logic pwm_meta;
        logic pwm_sync;
        logic [2:0] brt_low;
        logic [7:0] brt_high;
        blb_code_t brt_code;
        logic [7:0] rdata;
        blb_code_t led_code;
        logic boost_en;
        logic timeout;
        logic ramp_busy;
    } blb_top_s;

    // Scale a code by a duty code; full duty passes the code unchanged.
    function automatic blb_code_t blb_scale(input blb_code_t a, input blb_code_t d);
        logic [11:0] dd;
        logic [22:0] p;
        dd = (d == 11'h7FF) ? 12'h800 : {1'b0, d};
        p = {12'h000, a} * {11'h000, dd};
        return p[21:11];
    endfunction

endpackage

/* File: blb_duty_meter.sv */
//
// Purpose: Sample the synchronised pulse input, measure its duty and watch for silence.
// Assumes: i_pwm_lvl is already synchronised to i_clk_sys.
// Notes:   Duty is high samples over period samples, found by an 11-step division.
//
`timescale 1ns/10ps
`include "blb_cfg.svh"

module blb_duty_meter (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst_b,
    // Pulse level and settings
    input wire logic i_pwm_lvl,
    input wire logic [1:0] i_rate,
    input wire logic [22:0] i_tmo_cyc,
    // Results
    output blb_pkg::blb_code_t o_duty,
    output logic o_timeout
);

    blb_pkg::blb_dm_s st_r; // All meter state.
    blb_pkg::blb_dm_s st_nxt; // Next meter state.
    logic [7:0] div_last; // Last count of the sample divider.
    logic [21:0] rem2; // Doubled remainder.
    logic ge; // Quotient bit.

    // Sample rate divider end point; the fast rate rounds down to a whole cycle.
    always_comb begin
        unique case (i_rate)
            2'h0: div_last = 8'(`BLB_CLK_KHZ / `BLB_RATE_SLOW_KHZ - 1);
            2'h1: div_last = 8'(`BLB_CLK_KHZ / `BLB_RATE_MID_KHZ - 1);
            default: div_last = 8'(`BLB_CLK_KHZ / `BLB_RATE_FAST_KHZ - 1);
        endcase
    end

    // Sampling, period capture, division and timeout.
    always_comb begin
        st_nxt = st_r;
        rem2 = {st_r.rem, 1'b0};
        ge = (rem2 >= {2'h0, st_r.per_lat});
        st_nxt.div_cnt = (st_r.div_cnt >= div_last) ? 8'h00 : st_r.div_cnt + 8'h01;
        if (st_r.tmo_cnt < i_tmo_cyc) begin
            st_nxt.tmo_cnt = st_r.tmo_cnt + 23'h000001;
        end
        if (st_r.div_cnt >= div_last) begin
            st_nxt.lvl_prev = i_pwm_lvl;
            // Any edge proves the source is alive.
            if (i_pwm_lvl != st_r.lvl_prev) begin
                st_nxt.tmo_cnt = 23'h000000;
                st_nxt.timeout = 1'b0;
            end
            if (i_pwm_lvl && !st_r.lvl_prev) begin
                // A rising edge closes one period and opens the next.
                st_nxt.seen_edge = 1'b1;
                st_nxt.hi_cnt = 20'h00001;
                st_nxt.per_cnt = 20'h00001;
                if (st_r.seen_edge && st_r.st == blb_pkg::BLB_DM_MEASURE) begin
                    st_nxt.st = blb_pkg::BLB_DM_DIVIDE;
                    st_nxt.per_lat = st_r.per_cnt;
                    st_nxt.rem = {1'b0, st_r.hi_cnt};
                    st_nxt.idx = 4'hB;
                end
            end else begin
                // Counters saturate; a slower source is caught by the timeout.
                if (st_r.per_cnt != 20'hFFFFF) begin
                    st_nxt.per_cnt = st_r.per_cnt + 20'h00001;
                    st_nxt.hi_cnt = st_r.hi_cnt + {19'h00000, i_pwm_lvl};
                end
            end
        end
        // One quotient bit per clock gives floor(2048 * high / period).
        if (st_r.st == blb_pkg::BLB_DM_DIVIDE) begin
            st_nxt.rem = ge ? 21'(rem2 - {2'h0, st_r.per_lat}) : rem2[20:0];
            st_nxt.quo = {st_r.quo[9:0], ge};
            st_nxt.idx = st_r.idx - 4'h1;
            if (st_r.idx == 4'h1) begin
                st_nxt.st = blb_pkg::BLB_DM_MEASURE;
                st_nxt.duty = {st_r.quo[9:0], ge};
            end
        end
        // Silence: the duty follows the steady level and old periods are dropped.
        if (st_r.tmo_cnt >= i_tmo_cyc) begin
            st_nxt.timeout = 1'b1;
            st_nxt.seen_edge = 1'b0;
            st_nxt.duty = st_r.lvl_prev ? 11'h7FF : 11'h000;
        end
    end

    // State register.
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            st_r <= '{st: blb_pkg::BLB_DM_MEASURE, default: '0};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign o_duty = st_r.duty;
    assign o_timeout = st_r.timeout;

    // Timeout rises only after a full silent window.
    a_timeout_window: assert property (
        @(posedge i_clk_sys) disable iff (!i_rst_b)
        $rose(st_r.timeout) |-> ($past(st_r.tmo_cnt) >= $past(i_tmo_cyc)))
        else $error("timeout rose before the silent window ended");

endmodule // blb_duty_meter

/* File: blb_ramper.sv */
//
// Purpose: Step the brightness code one code at a time toward a target.
// Assumes: One step period tick per microsecond at STEP_CYC clocks.
// Notes:   Step time is 4 to the power of the setting, in microseconds.
//
`timescale 1ns/10ps
`include "blb_cfg.svh"

module blb_ramper #(
    parameter int STEP_CYC = `BLB_STEP_CYC
) (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst_b,
    // Target and step setting
    input blb_pkg::blb_code_t i_target,
    input wire logic [2:0] i_step_sel,
    // Ramped code
    output blb_pkg::blb_code_t o_code
);

    blb_pkg::blb_rmp_s st_r; // All ramper state.
    blb_pkg::blb_rmp_s st_nxt; // Next ramper state.
    logic us_tick; // Base period elapsed.
    logic [14:0] lim; // Base periods per step, less one.

    // Setting 0 gives 1 us per step, so a full swing takes about 2 ms.
    assign lim = 15'((15'h0001 << {i_step_sel, 1'b0}) - 15'h0001);
    assign us_tick = (st_r.ns_cnt == 8'(STEP_CYC - 1));

    // Retarget steps at once; later steps wait a full period each.
    always_comb begin
        st_nxt = st_r;
        st_nxt.prev_tgt = i_target;
        if (st_r.code == i_target) begin
            st_nxt.ns_cnt = 8'h00;
            st_nxt.us_cnt = 15'h0000;
        end else if (i_target != st_r.prev_tgt || (us_tick && st_r.us_cnt == lim)) begin
            // First step at once makes the ramp last step times code span less one.
            st_nxt.code = (i_target > st_r.code) ? st_r.code + 11'h001
                                                 : st_r.code - 11'h001;
            st_nxt.ns_cnt = 8'h00;
            st_nxt.us_cnt = 15'h0000;
        end else if (us_tick) begin
            st_nxt.ns_cnt = 8'h00;
            st_nxt.us_cnt = st_r.us_cnt + 15'h0001;
        end else begin
            st_nxt.ns_cnt = st_r.ns_cnt + 8'h01;
        end
    end

    // State register.
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign o_code = st_r.code;

    a_step_single: assert property (
        @(posedge i_clk_sys) disable iff (!i_rst_b)
        (st_r.code != $past(st_r.code)) |->
            (st_r.code == $past(st_r.code) + 11'h001 || st_r.code == $past(st_r.code) - 11'h001))
        else $error("ramper moved by more than one code");
    a_retarget_now: assert property (
        @(posedge i_clk_sys) disable iff (!i_rst_b)
        (i_target != st_r.prev_tgt && i_target != st_r.code) |=> (st_r.code != $past(st_r.code)))
        else $error("ramper did not step on a new target");
    a_hold_target: assert property (
        @(posedge i_clk_sys) disable iff (!i_rst_b)
        (i_target == st_r.code) |=> (st_r.code == $past(st_r.code)))
        else $error("ramper left a reached target");

endmodule // blb_ramper

/* File: blb_brightness_path.sv */
//
// Purpose: Brightness path of a two-string backlight driver, from registers and pulse
//          input to the LED current code and the boost enable.
// Assumes: Register strobes come from the serial bus slave on the same clock;
//          the pulse pin is asynchronous.
// Notes:   Mode, sample rate, ramp setting and boost request are plain inputs.
// Operation
// Three codes are kept: the register code,
// the measured duty and the ramped code.
// The mode bits combine them as follows:
//   00 - ramp the register code, pin ignored.
//   01 - ramp the duty, register ignored.
//   10 - scale register code by duty, ramp.
//   11 - ramp register code, then scale.
// The pin crosses in through two flip-flops;
// only the second stage reaches the meter.
// The meter samples once per divider tick,
// so a pulse shorter than a tick can be
// missed. That is the price of sampling,
// which keeps pin noise out of the LEDs.
// A duty result needs two rising edges, so
// the first period after reset or timeout
// yields nothing.
// The silent window counts system clocks.
// When it runs out the duty follows the
// steady level and, outside mode 00, the
// boost enable drops until the second edge.
// The ramper takes its first step at once,
// so a ramp lasts one step less than its
// span.
// Only the high byte write commits the
// joined code; a lone high byte write
// reuses the last low bits written.
// Reads answer one clock after the strobe
// and hold until the next read.
// Timing of a register change in mode 00:
//   edge 0 - high byte taken, code joined.
//   edge 1 - ramper takes its first step.
//   edge 2 - the step reaches the output.
// Later steps follow one period apart.
// Timing of a duty result: the closing
// rising edge is sampled on a tick, eleven
// clocks of division follow, then the duty
// holds until the next result or timeout.
// Limitations:
//   - Mode, rate, ramp setting and boost
//     request are plain inputs; a change
//     in mid-ramp just retargets.
//   - The fast rate is rounded to a whole
//     number of clocks.
//   - Duty codes are truncated, not rounded.
//
`timescale 1ns/10ps
`include "blb_cfg.svh"

module blb_brightness_path #(
    parameter int TMO_SLOW_CYC = `BLB_TMO_SLOW_US * `BLB_US_CYC,
    parameter int TMO_MID_CYC = `BLB_TMO_MID_US * `BLB_US_CYC,
    parameter int TMO_FAST_CYC = `BLB_TMO_FAST_US * `BLB_US_CYC
) (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst_b,
    // Register access from the serial bus slave
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [7:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    output logic [7:0] o_reg_rdata,
    // Configuration
    input wire logic [1:0] i_brt_mode,
    input wire logic [1:0] i_sample_rate,
    input wire logic [2:0] i_ramp_rate,
    input wire logic i_boost_req,
    // Pulse width input pin
    input wire logic i_pwm_pin,
    // Current setting and status
    output blb_pkg::blb_code_t o_led_code,
    output logic o_boost_en,
    output logic o_pwm_timeout,
    output logic o_ramp_busy
);

    // -------------------------------------------------------------------------------
    // Declarations
    // -------------------------------------------------------------------------------
    // All top level state is one packed record,
    // so register file, synchroniser and output
    // stage share one reset and one process.
    // The rest is glue between meter, ramper
    // and that record.
    blb_pkg::blb_top_s st_r; // All top level state.
    blb_pkg::blb_top_s st_nxt; // Next top level state.
    blb_pkg::blb_mode_e mode; // Decoded brightness mode.
    logic pwm_on; // Pulse input is in use.
    logic [22:0] tmo_cyc; // Silent window for the chosen rate.
    blb_pkg::blb_code_t dm_duty; // Measured duty code.
    logic dm_timeout; // No pulse seen in the window.
    blb_pkg::blb_code_t target; // Ramper target.
    blb_pkg::blb_code_t ramp_code; // Ramper output.
    blb_pkg::blb_code_t led_code; // Code before the output register.

    // -------------------------------------------------------------------------------
    // Mode and timeout selection
    // -------------------------------------------------------------------------------
    // Every two-bit code is a named mode, so
    // the cast never yields an unnamed value.
    assign mode = blb_pkg::blb_mode_e'(i_brt_mode);
    // Mode 00 leaves the pulse input out entirely, including its timeout.
    assign pwm_on = (mode != blb_pkg::BLB_MODE_REG);

    // The windows are parameters so a bench can
    // shorten them; defaults hold full lengths.
    // A rate code of 1x picks the fast window,
    // as the meter's divider does.
    // Silent window follows the sample rate; the slowest rate needs the longest.
    always_comb begin
        unique case (i_sample_rate)
            2'h0: tmo_cyc = 23'(TMO_SLOW_CYC);
            2'h1: tmo_cyc = 23'(TMO_MID_CYC);
            default: tmo_cyc = 23'(TMO_FAST_CYC);
        endcase
    end

    // -------------------------------------------------------------------------------
    // Duty measurement and ramping
    // -------------------------------------------------------------------------------
    // The meter sees only the second synchroniser stage.
    // Its timeout is raw; the mode mask is
    // applied further down.
    blb_duty_meter u_duty (
        .i_clk_sys(i_clk_sys),
        .i_rst_b(i_rst_b),
        .i_pwm_lvl(st_r.pwm_sync),
        .i_rate(i_sample_rate),
        .i_tmo_cyc(tmo_cyc),
        .o_duty(dm_duty),
        .o_timeout(dm_timeout)
    );

    // Target per mode; mode 11 ramps the register code alone.
    always_comb begin
        unique case (mode)
            blb_pkg::BLB_MODE_REG: target = st_r.brt_code;
            blb_pkg::BLB_MODE_PWM: target = dm_duty;
            blb_pkg::BLB_MODE_MUL_RAMP: target = blb_pkg::blb_scale(st_r.brt_code, dm_duty);
            blb_pkg::BLB_MODE_RAMP_MUL: target = st_r.brt_code;
        endcase
    end

    // The ramper runs in every mode; in mode 11
    // its target never sees the duty.
    blb_ramper u_ramp (
        .i_clk_sys(i_clk_sys),
        .i_rst_b(i_rst_b),
        .i_target(target),
        .i_step_sel(i_ramp_rate),
        .o_code(ramp_code)
    );

    // Mode 11 scales after the ramper, so duty changes reach the LEDs unramped.
    assign led_code = (mode == blb_pkg::BLB_MODE_RAMP_MUL) ?
                      blb_pkg::blb_scale(ramp_code, dm_duty) : ramp_code;

    // -------------------------------------------------------------------------------
    // Registers, synchroniser and outputs
    // -------------------------------------------------------------------------------
    // The pin is the only input from outside
    // this clock domain. Its first stage may
    // go metastable, so only the second stage
    // is read by any logic.
    // Strobes, mode and rate come from logic
    // on this clock and are used as they come.
    // A write and a read of one offset in one
    // cycle return the old byte, because read
    // data comes from the stored state.
    // Next state: pin synchroniser, register file, read data and output stage.
    always_comb begin
        st_nxt = st_r;
        st_nxt.pwm_meta = i_pwm_pin;
        st_nxt.pwm_sync = st_r.pwm_meta;
        if (i_reg_wr) begin
            if (i_reg_addr == `BLB_ADDR_BRT_LOW) begin
                // Held aside; the code in use does not move yet.
                st_nxt.brt_low = i_reg_wdata[2:0];
            end else if (i_reg_addr == `BLB_ADDR_BRT_HIGH) begin
                // The high byte commits the whole code, so write the low part first.
                st_nxt.brt_high = i_reg_wdata;
                st_nxt.brt_code = {i_reg_wdata, st_r.brt_low};
            end
        end
        // Reads return stored bytes; unused bits and unmapped offsets read zero.
        if (i_reg_rd) begin
            if (i_reg_addr == `BLB_ADDR_BRT_LOW) begin
                st_nxt.rdata = {5'h00, st_r.brt_low};
            end else if (i_reg_addr == `BLB_ADDR_BRT_HIGH) begin
                st_nxt.rdata = st_r.brt_high;
            end else begin
                st_nxt.rdata = 8'h00;
            end
        end
        st_nxt.led_code = led_code;
        // Boost is dropped while the enabled pulse input has gone silent.
        st_nxt.boost_en = i_boost_req && !(pwm_on && dm_timeout);
        st_nxt.timeout = pwm_on && dm_timeout;
        st_nxt.ramp_busy = (ramp_code != target);
    end

    // The joined code starts as the join of
    // the two reset bytes.
    // State register; reset values are constants only.
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            st_r <= '{brt_low: `BLB_BRT_LOW_RST, brt_high: `BLB_BRT_HIGH_RST,
                      brt_code: {`BLB_BRT_HIGH_RST, `BLB_BRT_LOW_RST}, default: '0};
        end else begin
            st_r <= st_nxt;
        end
    end

    // Outputs are plain flip-flop copies, so
    // no pin glitches with the logic behind.
    assign o_reg_rdata = st_r.rdata;
    assign o_led_code = st_r.led_code;
    assign o_boost_en = st_r.boost_en;
    assign o_pwm_timeout = st_r.timeout;
    assign o_ramp_busy = st_r.ramp_busy;

    // -------------------------------------------------------------------------------
    // Assertions
    // -------------------------------------------------------------------------------
    // All checks run on the system clock and
    // rest during reset. Those using $past look
    // one clock back, matching the single
    // output register before the pins.
    default clocking cb_sys @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_rst_b);

    a_low_write_hold: assert property (
        (i_reg_wr && i_reg_addr == `BLB_ADDR_BRT_LOW) |=> $stable(st_r.brt_code))
        else $error("low part write changed the code");
    a_high_write_join: assert property (
        (i_reg_wr && i_reg_addr == `BLB_ADDR_BRT_HIGH) |=>
            (st_r.brt_code == {$past(i_reg_wdata), $past(st_r.brt_low)}))
        else $error("high part write did not join the code");
    a_boost_cut: assert property (
        (pwm_on && dm_timeout) |=> !o_boost_en)
        else $error("boost stayed on after pulse timeout");
    a_reg_mode_pwm_free: assert property (
        (mode == blb_pkg::BLB_MODE_REG) |=> (!o_pwm_timeout && o_led_code == $past(ramp_code)))
        else $error("mode 00 reacted to the pulse input");
    a_pwm_mode_target: assert property (
        (mode == blb_pkg::BLB_MODE_PWM) |-> (target == dm_duty))
        else $error("mode 01 target is not the duty");
    a_mul_mode_target: assert property (
        (mode == blb_pkg::BLB_MODE_MUL_RAMP && dm_duty == 11'h7FF) |-> (target == st_r.brt_code))
        else $error("mode 10 full duty does not pass the code");
    a_ramp_mul_out: assert property (
        (mode == blb_pkg::BLB_MODE_RAMP_MUL && ramp_code == 11'h000) |=> (o_led_code == 11'h000))
        else $error("mode 11 scaled output wrong");
    a_ramp_mul_target: assert property (
        (mode == blb_pkg::BLB_MODE_RAMP_MUL) |-> (target == st_r.brt_code))
        else $error("mode 11 ramps on duty");

    // Boost follows the request while the
    // pulse input is healthy.
    a_boost_follow: assert property (
        !(pwm_on && dm_timeout) |=> (o_boost_en == $past(i_boost_req)))
        else $error("boost did not follow the request");

    // Busy reports the ramper one clock late.
    a_busy_flag: assert property (
        1'b1 |=> (o_ramp_busy == $past(ramp_code != target)))
        else $error("busy flag disagrees with the ramper");

    c_timeout_seen: cover property (pwm_on && dm_timeout);
    c_pwm_settled: cover property (mode == blb_pkg::BLB_MODE_PWM && !o_ramp_busy);
    c_ramp_mul_busy: cover property (mode == blb_pkg::BLB_MODE_RAMP_MUL && o_ramp_busy);
    c_high_write: cover property (i_reg_wr && i_reg_addr == `BLB_ADDR_BRT_HIGH);

endmodule // blb_brightness_path

/* File: blb_pwm_src.sv */
//
// Purpose: Behavioural pulse source that drives the brightness path's pulse pin.
// Assumes: Period and high time are whole nanoseconds.
// Notes:   Sends whole periods only; when stopped the pin rests at the idle level.
//
`timescale 1ns/10ps

module blb_pwm_src #(
    parameter int PER_NS = 4000,
    parameter int HI_NS = 80
) (
    // Control from the bench
    input wire logic i_run,
    input wire logic i_idle,
    // Pulse pin
    output logic o_pwm
);
    // A stop never cuts a period short, so no runt pulse reaches the meter.
    // A 250 kHz rate stays far above the roughly 1667 Hz floor of the fast rate.
    initial begin
        o_pwm = 1'b0;
        forever begin
            if (i_run) begin
                o_pwm = 1'b1;
                #(HI_NS);
                o_pwm = 1'b0;
                #(PER_NS - HI_NS);
            end else begin
                o_pwm = i_idle;
                #10;
            end
        end
    end
endmodule // blb_pwm_src

/* File: blb_brightness_path_tb.sv */
//
// Purpose: Self-checking bench of the brightness path.
// Assumes: Timeout counts shortened; fast sample rate throughout.
// Notes:   Inputs change on the falling edge only.
//
`timescale 1ns/10ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin num_errors++; \
    $display("unexpected at %0t: value mismatch", $time); end end

module blb_brightness_path_tb;
    logic clk = 1'b0, rst_b = 1'b0, wr = 1'b0, rd = 1'b0, boost_req = 1'b1;
    logic run = 1'b0, idle = 1'b0, pwm, boost_en, tmo, busy;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
    logic [1:0] mode = 2'h0;
    blb_pkg::blb_code_t led;
    int num_errors = 0, n_checks = 0;

    // 200 MHz system clock.
    always #2.5 clk = ~clk;

    blb_brightness_path #(.TMO_SLOW_CYC(4000), .TMO_MID_CYC(3000), .TMO_FAST_CYC(2000))
        blb_brightness_path_i (.i_clk_sys(clk), .i_rst_b(rst_b), .i_reg_wr(wr),
        .i_reg_rd(rd), .i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata),
        .i_brt_mode(mode), .i_sample_rate(2'h2), .i_ramp_rate(3'h0),
        .i_boost_req(boost_req), .i_pwm_pin(pwm), .o_led_code(led),
        .o_boost_en(boost_en), .o_pwm_timeout(tmo), .o_ramp_busy(busy));

    blb_pwm_src blb_pwm_src_i (.i_run(run), .i_idle(idle), .o_pwm(pwm));

    // Verdict and end of the run.
    task automatic complete_run();
        if (num_errors == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // One write strobe, held for exactly one rising edge.
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        wr = 1'b1;
        addr = a;
        wdata = d;
        @(negedge clk);
        wr = 1'b0;
    endtask

    // One read strobe; the data is settled by the next falling edge.
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk);
        rd = 1'b1;
        addr = a;
        @(negedge clk);
        rd = 1'b0;
        d = rdata;
    endtask

    // Waits, under a bound, until the ramp settles inside a code window.
    task automatic wait_led(input int lo, input int hi, input int bound, output logic ok);
        ok = 1'b0;
        for (int i = 0; i < bound && !ok; i++) begin
            @(negedge clk);
            ok = (busy === 1'b0) && (led >= lo) && (led <= hi);
        end
    endtask

    // Reset values, dropped bits, unmapped read, commit on the high part only.
    task automatic scen_reg_mode00();
        logic [7:0] d;
        logic ok;
        rd_reg(8'h18, d);
        `CHK(d, 8'h00)
        rd_reg(8'h44, d);
        `CHK(d, 8'h00)
        run = 1'b1;
        wr_reg(8'h18, 8'hFD);
        repeat (400) @(negedge clk);
        `CHK(led, 11'h000)
        rd_reg(8'h18, d);
        `CHK(d, 8'h05)
        wr_reg(8'h19, 8'h01);
        repeat (2000) @(negedge clk);
        `CHK(busy, 1'b1)
        wait_led(13, 13, 1000, ok);
        `CHK(ok, 1'b1)
    endtask

    // Pulse-only mode: a 2 percent duty gives a code near 40.
    task automatic scen_pwm_only();
        logic ok;
        mode = 2'h1;
        wait_led(37, 43, 15000, ok);
        `CHK(ok, 1'b1)
        `CHK(tmo, 1'b0)
    endtask

    // Silence times out and drops boost; mixed modes then pass the code at full duty.
    task automatic scen_timeout_mix();
        logic ok;
        run = 1'b0;
        repeat (2300) @(negedge clk);
        `CHK(tmo, 1'b1)
        `CHK(boost_en, 1'b0)
        idle = 1'b1;
        for (int m = 2; m < 4; m++) begin
            mode = m[1:0];
            wait_led(13, 13, 12000, ok);
            `CHK(ok, 1'b1)
        end
        mode = 2'h0;
        repeat (4) @(negedge clk);
        `CHK(tmo, 1'b0)
        `CHK(boost_en, 1'b1)
    endtask

    // Main sequence.
    initial begin
        repeat (12) @(negedge clk);
        rst_b = 1'b1;
        scen_reg_mode00();
        scen_pwm_only();
        scen_timeout_mix();
        complete_run();
    end
endmodule // blb_brightness_path_tb
